// >>> design/gcms_defs.svh
// register offsets, field positions and reset values of the gear/cam master select block
`ifndef GCMS_DEFS_SVH
`define GCMS_DEFS_SVH
`define GCMS_ADDR_W      8
`define GCMS_OFF_CYCLE   8'h00
`define GCMS_OFF_CAM1    8'h04
`define GCMS_OFF_CAMN    8'h08
`define GCMS_OFF_STATUS  8'h0C
`define GCMS_OFF_MASK    8'h10
`define GCMS_OFF_CAMST   8'h14
`define GCMS_OFF_SEL     8'h40
`define GCMS_OFF_TRIG    8'h80
`define GCMS_REGION_MSK  8'hC0
`define GCMS_RST_CYCLE   32'h00001388
`define GCMS_RST_TRIG    32'hFFFFFFFF
`define GCMS_RST_SEL     8'h00
`define GCMS_RST_MASK    3'h0
`define GCMS_CODE_AXIS   8'h00
`define GCMS_CODE_ENC    8'h20
`define GCMS_CODE_ADC    8'h50
`define GCMS_CAM1_EN_BIT 8
`define GCMS_CAMN_EN_LSB 16
`define GCMS_ST_SELERR   0
`define GCMS_ST_FIRED    1
`define GCMS_ST_CAMERR   2
`define GCMS_RESP_OKAY   2'h0
`define GCMS_RESP_SLVERR 2'h2
`endif

// >>> design/gcms_pkg.sv
// types shared by the gear/cam master select block
package gcms_pkg;
   localparam int STAT_W = 3;
   // per slave axis state
   typedef struct packed {
      logic [7:0]         sel;       // master selector code, zero = none
      logic               cam_en;    // camming running
      logic               armed;     // deferred start/stop waiting on master
      logic               arm_en;    // value cam_en takes when the trigger fires
      logic signed [31:0] arm_pos;   // trigger position latched at command time
      logic signed [31:0] trig;      // staged trigger position for next command
      logic signed [31:0] modpos;    // master position inside the cycle
      logic signed [31:0] mpos;      // raw master position
      logic signed [31:0] cmd;       // slave position command
   } gcms_axis_t;
   // bus slave state
   typedef struct packed {
      logic                aw_full;
      logic [7:0]          aw_addr;
      logic                w_full;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
   } gcms_bus_t;
endpackage

// >>> design/gcms_master_select.sv
// per-slave master source selection and camming start/stop control, AXI4-Lite slave
//
// Contract
// R1 - selector 1..15 picks an axis, 0x21..0x2F an encoder, 0x51..0x5F an ADC
// R2 - selector zero means no master; every selector resets to zero
// R3 - an axis may never be its own master; such a write is rejected
// R4 - each slave holds one selector; many slaves may share one master
// R5 - a geared slave axis stays selectable as master for other slaves
// R6 - host assigns a master before it enables gearing on that slave
// R7 - assignment to a disabled source is refused with an error
// R8 - axis master feeds its trajectory command, never its feedback position
// R9 - selecting an axis as master places no limit on its own mode
// R10 - slave command is geared motion plus point-to-point move, summed
// R11 - multi-axis cam command applies all listed axes in one cycle
// R12 - trigger position -1 starts or stops camming immediately
// R13 - trigger 0..cycle-1 defers until master position crosses it
// R14 - trigger limited to -1 or 0..cycle-1, for start and stop
// R15 - single-axis cam command sets or clears only the addressed axis
// R16 - reduced variant refuses ADC channels as master
// R17 - master position reduced modulo cycle, nonnegative, used for triggers
// R18 - reset: no master, camming off, trigger -1, nothing armed
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "gcms_defs.svh"

module gcms_master_select #(
   parameter int NAX     = 8,
   parameter int NENC    = 15,
   parameter int NADC    = 15,
   parameter bit REDUCED = 1'b0
) (
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   input  wire logic                           ce,
   input  wire logic [`GCMS_ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [`GCMS_ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   input  wire logic [NAX-1:0]                 axis_enabled,
   input  wire logic [NENC-1:0]                enc_enabled,
   input  wire logic [NADC-1:0]                adc_enabled,
   input  wire logic [NAX-1:0][31:0]           traj_pos,
   input  wire logic [NENC-1:0][31:0]          enc_pos,
   input  wire logic [NADC-1:0][31:0]          adc_val,
   input  wire logic [NAX-1:0][31:0]           geared_pos,
   input  wire logic [NAX-1:0][31:0]           ptp_pos,
   output logic [NAX-1:0][31:0]                master_pos,
   output logic [NAX-1:0][31:0]                master_cycle_pos,
   output logic [NAX-1:0][31:0]                slave_cmd,
   output logic [NAX-1:0]                      cam_enabled,
   output logic                                irq
);
   import gcms_pkg::*;

   // elaboration-time limits: selector codes only reach 15 of each kind
   if (NAX < 1 || NAX > 15 || NENC < 1 || NENC > 15 || NADC < 1 || NADC > 15) begin : g_chk
      $error("gcms_master_select: NAX, NENC and NADC must lie in 1..15");
   end

   typedef struct packed {
      gcms_bus_t                  bus;
      gcms_axis_t [NAX-1:0]       ax;
      logic signed [31:0]         cycle;
      logic [STAT_W-1:0]          status;
      logic [STAT_W-1:0]          mask;
      logic                       irq;
   } gcms_state_t;

   gcms_state_t s;
   gcms_state_t next_s;

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // a selector write is legal when it names an existing, enabled, foreign source
   function automatic logic sel_legal(input logic [7:0] code, input int slave);
      logic ok;
      int   k;
      ok = 1'b0;
      k  = int'(code[3:0]);
      if (code == `GCMS_RST_SEL) begin
         ok = 1'b1;                                                        // R2
      end else if (code[7:4] == `GCMS_CODE_AXIS >> 4 && k >= 1 && k <= NAX) begin
         ok = (k != slave + 1) && axis_enabled[k-1];                       // R3 R7 R5
      end else if (code[7:4] == `GCMS_CODE_ENC >> 4 && k >= 1 && k <= NENC) begin
         ok = enc_enabled[k-1];                                            // R7
      end else if (code[7:4] == `GCMS_CODE_ADC >> 4 && k >= 1 && k <= NADC) begin
         ok = !REDUCED && adc_enabled[k-1];                                // R16 R7
      end
      return ok;                                                           // R1
   endfunction

   // master source mux; a code that names no existing source reads zero, source enables are not checked
   function automatic logic [31:0] src_pos(input logic [7:0] code);
      logic [31:0] p;
      int          k;
      p = 32'h00000000;
      k = int'(code[3:0]);
      if (code[7:4] == `GCMS_CODE_AXIS >> 4 && k >= 1 && k <= NAX) begin
         p = traj_pos[k-1];                                                // R8 R9
      end else if (code[7:4] == `GCMS_CODE_ENC >> 4 && k >= 1 && k <= NENC) begin
         p = enc_pos[k-1];
      end else if (code[7:4] == `GCMS_CODE_ADC >> 4 && k >= 1 && k <= NADC && !REDUCED) begin
         p = adc_val[k-1];                                                 // R16
      end
      return p;                                                            // R1
   endfunction

   // register read view
   function automatic logic [31:0] rd_val(input gcms_state_t st, input logic [7:0] a);
      logic [31:0] v;
      int          i;
      v = 32'h00000000;
      i = int'(a[5:2]);
      if (a == `GCMS_OFF_CYCLE) begin
         v = st.cycle;
      end else if (a == `GCMS_OFF_STATUS) begin
         v[STAT_W-1:0] = st.status;
      end else if (a == `GCMS_OFF_MASK) begin
         v[STAT_W-1:0] = st.mask;
      end else if (a == `GCMS_OFF_CAMST) begin
         for (int j = 0; j < NAX; j++) begin
            v[j]                     = st.ax[j].cam_en;
            v[`GCMS_CAMN_EN_LSB + j] = st.ax[j].armed;
         end
      end else if ((a & `GCMS_REGION_MSK) == `GCMS_OFF_SEL && i < NAX) begin
         v[7:0] = st.ax[i].sel;
      end else if ((a & `GCMS_REGION_MSK) == `GCMS_OFF_TRIG && i < NAX) begin
         v = st.ax[i].trig;
      end
      return v;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      logic [7:0] r;
      r = a & `GCMS_REGION_MSK;
      return a == `GCMS_OFF_CYCLE || a == `GCMS_OFF_CAM1 || a == `GCMS_OFF_CAMN
          || a == `GCMS_OFF_STATUS || a == `GCMS_OFF_MASK || a == `GCMS_OFF_CAMST
          || ((r == `GCMS_OFF_SEL || r == `GCMS_OFF_TRIG) && int'(a[5:2]) < NAX
              && a[1:0] == 2'h0);
   endfunction

   // handshake outputs straight from state
   assign s_axi_awready = !s.bus.aw_full && !s.bus.bvalid;
   assign s_axi_wready  = !s.bus.w_full && !s.bus.bvalid;
   assign s_axi_arready = !s.bus.rvalid;

   // next-state logic: bus, selectors, cam commands, trigger watch
   always_comb begin
      logic [STAT_W-1:0]  ev;
      logic [31:0]        wv;
      logic [7:0]         wa;
      logic signed [31:0] mp;
      logic signed [31:0] r;
      logic signed [31:0] tp;
      logic               hit;
      logic               rd_stat;
      int                 wi;
      logic [NAX-1:0]     go;
      logic [NAX-1:0]     go_en;
      ev      = '0;
      wv      = 32'h00000000;
      wa      = 8'h00;
      mp      = 32'sh00000000;
      r       = 32'sh00000000;
      tp      = 32'sh00000000;
      hit     = 1'b0;
      rd_stat = 1'b0;
      wi      = 0;
      go      = '0;
      go_en   = '0;
      next_s  = s;

      // per axis: master position, cycle reduction, deferred trigger
      for (int i = 0; i < NAX; i++) begin
         mp = src_pos(s.ax[i].sel);                                        // R4
         if (s.cycle > 0) begin
            r = mp % s.cycle;
            if (r < 0) begin
               r = r + s.cycle;                                            // R17
            end
         end else begin
            r = 32'sh00000000;
         end
         next_s.ax[i].mpos   = mp;
         next_s.ax[i].modpos = r;
         // crossing: trigger lies between old and new in-cycle position
         if (s.ax[i].modpos <= r) begin
            hit = s.ax[i].arm_pos > s.ax[i].modpos && s.ax[i].arm_pos <= r;
         end else begin
            hit = s.ax[i].arm_pos < s.ax[i].modpos && s.ax[i].arm_pos >= r;
         end
         if (s.ax[i].armed && hit) begin
            next_s.ax[i].cam_en = s.ax[i].arm_en;                          // R13
            next_s.ax[i].armed  = 1'b0;
            ev[`GCMS_ST_FIRED]  = 1'b1;
         end
         next_s.ax[i].cmd = geared_pos[i] + ptp_pos[i];                    // R10
      end

      // write address and data are taken independently, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.bus.aw_full = 1'b1;
         next_s.bus.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.bus.w_full = 1'b1;
         next_s.bus.w_data = s_axi_wdata;
         next_s.bus.w_strb = s_axi_wstrb;
      end
      if (s.bus.bvalid && s_axi_bready) begin
         next_s.bus.bvalid = 1'b0;
      end

      // write execution once both halves are held
      if (s.bus.aw_full && s.bus.w_full) begin
         wa = s.bus.aw_addr;
         wi = int'(wa[5:2]);
         wv = s.bus.w_data;
         next_s.bus.aw_full = 1'b0;
         next_s.bus.w_full  = 1'b0;
         next_s.bus.bvalid  = 1'b1;
         next_s.bus.bresp   = mapped(wa) ? `GCMS_RESP_OKAY : `GCMS_RESP_SLVERR;
         if (!mapped(wa)) begin
            next_s.bus.bresp = `GCMS_RESP_SLVERR;
         end else if (wa == `GCMS_OFF_CYCLE) begin
            next_s.cycle = merge(s.cycle, wv, s.bus.w_strb);
         end else if (wa == `GCMS_OFF_MASK) begin
            next_s.mask = STAT_W'(merge(32'(s.mask), wv, s.bus.w_strb));
         end else if (wa == `GCMS_OFF_CAM1) begin
            // single axis: number in the low nibble, enable flag above it
            if (int'(wv[3:0]) >= 1 && int'(wv[3:0]) <= NAX) begin
               go[int'(wv[3:0]) - 1]    = 1'b1;                            // R15
               go_en[int'(wv[3:0]) - 1] = wv[`GCMS_CAM1_EN_BIT];
            end else begin
               ev[`GCMS_ST_CAMERR] = 1'b1;
               next_s.bus.bresp    = `GCMS_RESP_SLVERR;
            end
         end else if (wa == `GCMS_OFF_CAMN) begin
            go    = wv[NAX-1:0];                                           // R11
            go_en = wv[`GCMS_CAMN_EN_LSB +: NAX];
         end else if ((wa & `GCMS_REGION_MSK) == `GCMS_OFF_SEL) begin
            wv = merge(32'(s.ax[wi].sel), wv, s.bus.w_strb);
            if (sel_legal(wv[7:0], wi)) begin
               next_s.ax[wi].sel = wv[7:0];                                // R4
            end else begin
               ev[`GCMS_ST_SELERR] = 1'b1;                                 // R3 R7 R16
               next_s.bus.bresp    = `GCMS_RESP_SLVERR;
            end
         end else if ((wa & `GCMS_REGION_MSK) == `GCMS_OFF_TRIG) begin
            next_s.ax[wi].trig = merge(s.ax[wi].trig, wv, s.bus.w_strb);
         end
      end

      // cam commands: every listed axis with a trigger of -1 or 0..cycle-1 is updated in the same cycle
      for (int i = 0; i < NAX; i++) begin
         tp = s.ax[i].trig;
         if (go[i]) begin
            if (tp == `GCMS_RST_TRIG) begin
               next_s.ax[i].cam_en = go_en[i];                             // R12
               next_s.ax[i].armed  = 1'b0;
            end else if (tp >= 0 && tp < s.cycle) begin
               next_s.ax[i].armed   = 1'b1;                                // R13
               next_s.ax[i].arm_en  = go_en[i];
               next_s.ax[i].arm_pos = tp;
            end else begin
               ev[`GCMS_ST_CAMERR] = 1'b1;                                 // R14
               next_s.bus.bresp    = `GCMS_RESP_SLVERR;
            end
         end
      end

      // read channel: one read in flight, data registered
      if (s.bus.rvalid && s_axi_rready) begin
         next_s.bus.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.bus.rvalid = 1'b1;
         next_s.bus.rdata  = rd_val(s, s_axi_araddr);
         next_s.bus.rresp  = mapped(s_axi_araddr) ? `GCMS_RESP_OKAY : `GCMS_RESP_SLVERR;
         rd_stat           = s_axi_araddr == `GCMS_OFF_STATUS;
      end

      // sticky status: read clears, but a same-cycle event still lands
      next_s.status = (rd_stat ? '0 : s.status) | ev;
      next_s.irq    = |(next_s.status & next_s.mask);
   end

   // one register for all state; clock enable freezes everything except the synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s        <= '0;
         s.cycle  <= `GCMS_RST_CYCLE;
         s.mask   <= `GCMS_RST_MASK;
         for (int i = 0; i < NAX; i++) begin
            s.ax[i].sel     <= `GCMS_RST_SEL;                              // R18 R2
            s.ax[i].trig    <= `GCMS_RST_TRIG;                             // R18
            s.ax[i].arm_pos <= `GCMS_RST_TRIG;
         end
      end else if (ce) begin
         s <= next_s;
      end
   end

   // outputs from state
   assign s_axi_bvalid = s.bus.bvalid;
   assign s_axi_bresp  = s.bus.bresp;
   assign s_axi_rvalid = s.bus.rvalid;
   assign s_axi_rdata  = s.bus.rdata;
   assign s_axi_rresp  = s.bus.rresp;
   assign irq          = s.irq;

   // per-axis data outputs
   always_comb begin
      for (int i = 0; i < NAX; i++) begin
         master_pos[i]       = s.ax[i].mpos;
         master_cycle_pos[i] = s.ax[i].modpos;
         slave_cmd[i]        = s.ax[i].cmd;
         cam_enabled[i]      = s.ax[i].cam_en;
      end
   end

endmodule // gcms_master_select

// >>> sim/gcms_master_select_assertions.sv
// concurrent checks on the ports of the gear/cam master select block
`timescale 1ns/10ps
module gcms_master_select_checker #(
   parameter int NAX = 8
) (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  ce,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [NAX-1:0][31:0]  geared_pos,
   input wire logic [NAX-1:0][31:0]  ptp_pos,
   input wire logic [NAX-1:0][31:0]  slave_cmd,
   input wire logic [NAX-1:0][31:0]  master_cycle_pos,
   input wire logic [NAX-1:0]        cam_enabled,
   input wire logic                  irq
);
   logic [NAX-1:0][31:0] sum_cmd;
   logic                 modpos_neg;
   // expected slave command and sign of every in-cycle master position
   always_comb begin
      modpos_neg = 1'b0;
      for (int j = 0; j < NAX; j++) begin
         sum_cmd[j] = geared_pos[j] + ptp_pos[j];
         modpos_neg = modpos_neg | master_cycle_pos[j][31];
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // reset must be seen through, so this one is not disabled by it
   a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && !irq && cam_enabled == '0)
      else $error("outputs not idle after reset");
   a_cmd_sum: assert property (ce |=> slave_cmd == $past(sum_cmd))
      else $error("slave command is not geared plus move");
   a_modpos_range: assert property (!modpos_neg)
      else $error("in-cycle master position negative");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && ce |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
endmodule // gcms_master_select_checker

bind gcms_master_select gcms_master_select_checker #(.NAX(NAX)) u_checker (.*);

// >>> sim/gcms_src_model.sv
// position sources standing in for axes, encoders and adc channels
`timescale 1ns/10ps
module gcms_src_model #(
   parameter int NAX  = 4,
   parameter int NENC = 2,
   parameter int NADC = 2
) (
   input  wire logic                  aclk,
   input  wire logic                  run,
   input  wire logic [31:0]           start,
   output logic [NAX-1:0][31:0]       traj_pos,
   output logic [NENC-1:0][31:0]      enc_pos,
   output logic [NADC-1:0][31:0]      adc_val
);
   // trajectory commands park at start plus 0x100 per axis index, then count up one per cycle
   always_ff @(posedge aclk) begin
      for (int k = 0; k < NAX; k++) begin
         traj_pos[k] <= run ? traj_pos[k] + 32'h1 : start + 32'h100 * 32'(k);
      end
   end
   // fixed, distinct values so a wrong source pick cannot pass unseen
   always_comb begin
      for (int e = 0; e < NENC; e++) enc_pos[e] = 32'h0010_0000 + 32'(e);
      for (int e = 0; e < NADC; e++) adc_val[e] = 32'h0000_0200 + 32'(e);
   end
endmodule // gcms_src_model

// >>> sim/gcms_master_select_tb_top.sv
// self-checking bench for the gear/cam master select block
`timescale 1ns/10ps
`include "gcms_defs.svh"
module gcms_master_select_tb_top;
   localparam int NAX = 4;
   localparam logic [1:0] OK = `GCMS_RESP_OKAY;
   localparam logic [1:0] ERR = `GCMS_RESP_SLVERR;
   // selector writes to slave 1: value, response, value read back
   localparam logic [7:0] SV[9] = '{8'h02, 8'h01, 8'h04, 8'h21, 8'h22, 8'h51, 8'h10, 8'h5F, 8'h00};
   localparam logic [1:0] SR[9] = '{OK, ERR, ERR, OK, ERR, OK, ERR, ERR, OK};
   localparam logic [7:0] SB[9] = '{8'h02, 8'h02, 8'h02, 8'h21, 8'h21, 8'h51, 8'h51, 8'h51, 8'h00};
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, run = 1'b0, irq;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid, s_axi_rvalid;
   logic s_axi_awready, s_axi_wready, s_axi_arready;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, start = 32'h0000_1000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, enc_enabled = 2'b01, adc_enabled = 2'b11;
   logic [NAX-1:0] axis_enabled = 4'b0111, cam_enabled;
   logic [NAX-1:0][31:0] geared_pos = '0, ptp_pos = '0, traj_pos, master_pos;
   logic [NAX-1:0][31:0] master_cycle_pos, slave_cmd;
   logic [1:0][31:0] enc_pos, adc_val;
   int fail_count = 0, comparisons = 0, cycles = 0;

   gcms_master_select #(.NAX(NAX), .NENC(2), .NADC(2)) i_dut (.*);
   gcms_src_model #(.NAX(NAX), .NENC(2), .NADC(2)) i_src (.*);

   always #12.5 aclk = ~aclk;

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a hang ends the run as a mismatch
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] slot(input logic [7:0] base, input int k);
      return base + 8'(4 * (k - 1));
   endfunction

   // bready is raised only once bvalid is seen, so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   initial begin
      int n;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // reset contents and an unmapped place
      for (int k = 1; k <= NAX; k++) begin
         rd(slot(`GCMS_OFF_SEL, k), 32'h0, OK);
         rd(slot(`GCMS_OFF_TRIG, k), `GCMS_RST_TRIG, OK);
      end
      rd(`GCMS_OFF_CAMST, 32'h0, OK);
      rd(`GCMS_OFF_CYCLE, `GCMS_RST_CYCLE, OK);
      rd(8'h3C, 32'h0, ERR);
      wr(8'h3C, 32'h1, ERR);
      // every selector class, self, disabled and undefined codes
      for (int i = 0; i < 9; i++) begin
         wr(slot(`GCMS_OFF_SEL, 1), 32'(SV[i]), SR[i]);
         rd(slot(`GCMS_OFF_SEL, 1), 32'(SB[i]), OK);
      end
      chk(master_pos[0], 32'h0);
      // interrupt raised, cleared by reading, then masked
      wr(`GCMS_OFF_MASK, 32'h1, OK);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h1);
      rd(`GCMS_OFF_STATUS, 32'h1, OK);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
      wr(`GCMS_OFF_MASK, 32'h0, OK);
      wr(slot(`GCMS_OFF_SEL, 2), 32'h02, ERR);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
      rd(`GCMS_OFF_STATUS, 32'h1, OK);
      // shared master, chained slave, adc master
      wr(slot(`GCMS_OFF_SEL, 1), 32'h02, OK);
      wr(slot(`GCMS_OFF_SEL, 2), 32'h01, OK);
      wr(slot(`GCMS_OFF_SEL, 3), 32'h02, OK);
      wr(slot(`GCMS_OFF_SEL, 4), 32'h51, OK);
      repeat (2) @(posedge aclk);
      chk(master_pos[0], 32'h0000_1100);
      chk(master_pos[1], 32'h0000_1000);
      chk(master_pos[2], 32'h0000_1100);
      chk(master_pos[3], 32'h0000_0200);
      // geared motion plus point-to-point move
      for (int j = 0; j < NAX; j++) begin
         geared_pos[j] <= 32'h100 * 32'(j + 1);
         ptp_pos[j] <= 32'hFFFF_FFF0 - 32'(j);
      end
      repeat (3) @(posedge aclk);
      // geared part plus the move, which is 0x10 plus the axis index below zero
      for (int j = 0; j < NAX; j++) begin
         chk(slave_cmd[j], 32'h100 * 32'(j + 1) - 32'h10 - 32'(j));
      end
      // immediate start and stop, list and single forms
      wr(`GCMS_OFF_CAMN, 32'h0005_0005, OK);
      chk(32'(cam_enabled), 32'h5);
      wr(`GCMS_OFF_CAM1, 32'h0000_0102, OK);
      chk(32'(cam_enabled), 32'h7);
      wr(`GCMS_OFF_CAM1, 32'h0000_0001, OK);
      chk(32'(cam_enabled), 32'h6);
      wr(`GCMS_OFF_CAMN, 32'h0000_0006, OK);
      chk(32'(cam_enabled), 32'h0);
      wr(`GCMS_OFF_CAM1, 32'h0000_0105, ERR);
      // trigger equal to the cycle is outside the allowed range
      wr(`GCMS_OFF_CYCLE, 32'h64, OK);
      wr(slot(`GCMS_OFF_TRIG, 1), 32'h64, OK);
      wr(`GCMS_OFF_CAM1, 32'h0000_0101, ERR);
      chk(32'(cam_enabled), 32'h0);
      rd(`GCMS_OFF_STATUS, 32'h4, OK);
      // deferred start from a negative master position
      start <= 32'hFFFF_FE06;
      repeat (4) @(posedge aclk);
      chk(master_cycle_pos[0], 32'h32);
      wr(slot(`GCMS_OFF_TRIG, 1), 32'h3C, OK);
      wr(`GCMS_OFF_CAM1, 32'h0000_0101, OK);
      rd(`GCMS_OFF_CAMST, 32'h0001_0000, OK);
      run <= 1'b1;
      n = 0;
      while (cam_enabled[0] !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(master_cycle_pos[0] >= 32'h3C && master_cycle_pos[0] <= 32'h3E), 32'h1);
      run <= 1'b0;
      rd(`GCMS_OFF_STATUS, 32'h2, OK);
      stop_test();
   end
endmodule // gcms_master_select_tb_top
